// ==== inc/sli_pkg.sv ====
// Constants, register map and enumerations for the status lamp indicator
package sli_pkg;

	// --------------------------------------------------------------
	// Timebase
	// --------------------------------------------------------------
	localparam int unsigned CLK_HZ = 40000000;
	localparam int unsigned ONE_SEC_S = 1;
	localparam int unsigned SEC_CYCLES = CLK_HZ * ONE_SEC_S;
	localparam int unsigned HOLD_S = 2;
	localparam int unsigned PAIR_PERIOD_S = 2;
	localparam int unsigned PAIR_LAMP_S = 60;
	localparam int unsigned PEND_TIMEOUT_S = 20;
	localparam int unsigned FAIL_HOLD_S = 1;
	localparam int unsigned TRIPLE_FLASHES = 3;

	// Tick divider: 16 sub-ticks per second drive all patterns
	localparam int unsigned SUB_PER_SEC = 16;
	localparam logic [3:0] SUB_LAST = 4'hf;
	localparam logic [3:0] SUB_HALF = 4'h8;
	localparam logic [3:0] SUB_MOSTLY_OFF = 4'he;
	localparam logic [3:0] SUB_SHORT_ON = 4'h2;

	// --------------------------------------------------------------
	// Register map (byte addresses)
	// --------------------------------------------------------------
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] COND_OFS = 8'h04;
	localparam logic [7:0] EVENT_OFS = 8'h08;
	localparam logic [7:0] STATUS_OFS = 8'h0c;

	// CTRL bits
	localparam int CTRL_USB = 0;
	localparam int CTRL_AUTHREQ = 1;
	localparam int CTRL_CONNLAMP = 2;
	localparam int CTRL_WIRELESS = 3;
	// COND bits
	localparam int COND_CHARGING = 0;
	localparam int COND_AUTHOK = 1;
	localparam int COND_AUTHFAIL = 2;
	localparam int COND_TAMPER = 3;
	localparam int COND_FWUPD = 4;
	localparam int COND_LOWBATT = 5;
	localparam int COND_PENDING = 6;
	localparam int COND_CONNECTED = 7;
	localparam int COND_PAIRING = 8;
	// EVENT bits (write-one pulses)
	localparam int EV_DECODE_OK = 0;
	localparam int EV_DECODE_BAD = 1;
	localparam int EV_SEND_FAIL = 2;
	localparam int EV_SWIPE = 3;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Lamp colour codes
	typedef enum logic [3:0] {
		COL_OFF = 4'h1,
		COL_GREEN = 4'h2,
		COL_AMBER = 4'h4,
		COL_RED = 4'h8
	} sli_col_t;

	typedef enum logic [2:0] {
		BTN_IDLE = 3'h1,
		BTN_FLASH = 3'h2,
		BTN_WAITREL = 3'h4
	} sli_btn_t;

endpackage

// ==== hw/sli_status_lamps.sv ====
// Status lamp indicator with AXI4-Lite control
`timescale 1ns/1ps

module sli_status_lamps #(
	parameter int unsigned SEC_CYCLES = sli_pkg::SEC_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic buttonN,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic greenOn,
	output logic amberOn,
	output logic redOn,
	output logic blueOn,
	output logic pairRequest
);

	localparam int unsigned SUB_CYCLES = SEC_CYCLES / sli_pkg::SUB_PER_SEC;

	// ------------------------------------------------------------
	// Register bus
	// ------------------------------------------------------------
	logic [3:0] ctrl_r;
	logic [8:0] cond_r;
	logic [3:0] evPulse;
	logic [7:0] awAddr_r;
	logic awHave_r, wHave_r;
	logic [31:0] wData_r;
	logic [3:0] wStrb_r;
	logic doWrite;
	logic [31:0] status;

	assign doWrite = awHave_r && wHave_r && !s_axi_bvalid;

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			awHave_r <= 1'b0;
			wHave_r <= 1'b0;
			awAddr_r <= 8'h00;
			wData_r <= 32'h0;
			wStrb_r <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= sli_pkg::RESP_OKAY;
		end
		else
		begin
			s_axi_awready <= !awHave_r && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !wHave_r && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				awHave_r <= 1'b1;
				awAddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wHave_r <= 1'b1;
				wData_r <= s_axi_wdata;
				wStrb_r <= s_axi_wstrb;
			end
			if (doWrite)
			begin
				awHave_r <= 1'b0;
				wHave_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awAddr_r[7:2] <= sli_pkg::EVENT_OFS[7:2]) ?
					sli_pkg::RESP_OKAY : sli_pkg::RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ctrl_r <= 4'h0;
			cond_r <= 9'h000;
			evPulse <= 4'h0;
		end
		else
		begin
			evPulse <= 4'h0;
			if (doWrite && wStrb_r[0])
			begin
				unique case (awAddr_r)
					sli_pkg::CTRL_OFS: ctrl_r <= wData_r[3:0];
					sli_pkg::COND_OFS: cond_r <= wData_r[8:0];
					sli_pkg::EVENT_OFS: evPulse <= wData_r[3:0];
					default: ;
				endcase
			end
			if (doWrite && wStrb_r[1] && awAddr_r == sli_pkg::COND_OFS)
				cond_r[8] <= wData_r[8];
		end
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= sli_pkg::RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= sli_pkg::RESP_OKAY;
				unique case (s_axi_araddr)
					sli_pkg::CTRL_OFS: s_axi_rdata <= {28'h0, ctrl_r};
					sli_pkg::COND_OFS: s_axi_rdata <= {23'h0, cond_r};
					sli_pkg::EVENT_OFS: s_axi_rdata <= 32'h0;
					sli_pkg::STATUS_OFS: s_axi_rdata <= status;
					default:
					begin
						s_axi_rdata <= 32'h0;
						s_axi_rresp <= sli_pkg::RESP_SLVERR;
					end
				endcase
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Timebase
	// ------------------------------------------------------------
	logic [31:0] div_r;
	logic [3:0] sub_r;
	logic subTick, secTick;

	assign subTick = div_r == 32'(SUB_CYCLES - 1);
	assign secTick = subTick && sub_r == sli_pkg::SUB_LAST;

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			div_r <= 32'h0;
			sub_r <= 4'h0;
		end
		else
		begin
			div_r <= subTick ? 32'h0 : div_r + 32'h1;
			if (subTick)
				sub_r <= sub_r + 4'h1;
		end
	end

	// ------------------------------------------------------------
	// Button synchroniser and hold timing
	// ------------------------------------------------------------
	logic [2:0] btnSync_r;
	logic pressed_r;
	sli_pkg::sli_btn_t btn_r;
	logic [7:0] holdSec_r;
	logic [5:0] flashSub_r;

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			btnSync_r <= 3'h7;
			pressed_r <= 1'b0;
		end
		else
		begin
			btnSync_r <= {btnSync_r[1:0], buttonN};
			if (btnSync_r[2] == btnSync_r[1])
				pressed_r <= !btnSync_r[2];
		end
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			btn_r <= sli_pkg::BTN_IDLE;
			holdSec_r <= 8'h0;
			flashSub_r <= 6'h0;
			pairRequest <= 1'b0;
		end
		else
		begin
			pairRequest <= 1'b0;
			unique case (btn_r)
				sli_pkg::BTN_IDLE:
				begin
					// Counted in sub-ticks so a press can qualify up to one sub-tick early
					if (!pressed_r)
						holdSec_r <= 8'h0;
					else if (subTick)
						holdSec_r <= holdSec_r + 8'h1;
					if (pressed_r && holdSec_r == 8'(sli_pkg::HOLD_S * sli_pkg::SUB_PER_SEC))
					begin
						btn_r <= sli_pkg::BTN_FLASH;
						flashSub_r <= 6'h0;
					end
				end
				sli_pkg::BTN_FLASH:
				begin
					if (subTick)
						flashSub_r <= flashSub_r + 6'h1;
					if (subTick && flashSub_r == 6'(sli_pkg::TRIPLE_FLASHES * 4 - 1))
						btn_r <= sli_pkg::BTN_WAITREL;
				end
				sli_pkg::BTN_WAITREL:
				begin
					if (!pressed_r)
					begin
						btn_r <= sli_pkg::BTN_IDLE;
						holdSec_r <= 8'h0;
						pairRequest <= 1'b1;
					end
				end
				default: btn_r <= sli_pkg::BTN_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Result pulses, pending and pairing timers
	// ------------------------------------------------------------
	sli_pkg::sli_col_t pulseCol_r;
	logic [31:0] pulseSub_r;
	logic [4:0] lowCnt_r;
	logic [5:0] pendSec_r;
	logic [6:0] pairSec_r;
	logic [1:0] pairPhase_r;
	logic usb, pending, pairing;

	assign usb = ctrl_r[sli_pkg::CTRL_USB];
	assign pending = cond_r[sli_pkg::COND_PENDING];
	assign pairing = cond_r[sli_pkg::COND_PAIRING];

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pulseCol_r <= sli_pkg::COL_OFF;
			pulseSub_r <= 32'h0;
			lowCnt_r <= 5'h0;
		end
		else
		begin
			// Counted in cycles so the pulse is exactly one second long
			if (pulseSub_r != 32'h0)
				pulseSub_r <= pulseSub_r - 32'h1;
			if (lowCnt_r != 5'h0 && subTick)
				lowCnt_r <= lowCnt_r - 5'h1;
			// New results restart the one-second pulse; latest wins
			if (evPulse[sli_pkg::EV_SWIPE] && !usb && cond_r[sli_pkg::COND_LOWBATT])
				lowCnt_r <= 5'(sli_pkg::SUB_PER_SEC);
			if (evPulse[sli_pkg::EV_DECODE_OK])
			begin
				pulseCol_r <= sli_pkg::COL_GREEN;
				pulseSub_r <= 32'(SEC_CYCLES);
			end
			if (evPulse[sli_pkg::EV_DECODE_BAD])
			begin
				pulseCol_r <= sli_pkg::COL_RED;
				pulseSub_r <= 32'(SEC_CYCLES);
			end
			if (evPulse[sli_pkg::EV_SEND_FAIL] && ctrl_r[sli_pkg::CTRL_WIRELESS])
			begin
				pulseCol_r <= sli_pkg::COL_AMBER;
				pulseSub_r <= 32'(SEC_CYCLES * sli_pkg::FAIL_HOLD_S);
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pendSec_r <= 6'h0;
			pairSec_r <= 7'h0;
			pairPhase_r <= 2'h0;
		end
		else
		begin
			// Timeout restarts whenever new data becomes pending
			if (!pending || cond_r[sli_pkg::COND_CONNECTED])
				pendSec_r <= 6'h0;
			else if (secTick && pendSec_r != 6'(sli_pkg::PEND_TIMEOUT_S))
				pendSec_r <= pendSec_r + 6'h1;
			if (!pairing)
			begin
				pairSec_r <= 7'h0;
				pairPhase_r <= 2'h0;
			end
			else if (secTick)
			begin
				pairPhase_r <= (pairPhase_r == 2'(sli_pkg::PAIR_PERIOD_S - 1)) ?
					2'h0 : pairPhase_r + 2'h1;
				if (pairSec_r != 7'(sli_pkg::PAIR_LAMP_S))
					pairSec_r <= pairSec_r + 7'h1;
			end
		end
	end

	// ------------------------------------------------------------
	// Lamp selection
	// ------------------------------------------------------------
	sli_pkg::sli_col_t genCol;
	logic slowBlink, rapid, mostly, shortFlash, blue;

	assign slowBlink = sub_r < sli_pkg::SUB_HALF;
	assign rapid = sub_r[0];
	assign mostly = sub_r < sli_pkg::SUB_MOSTLY_OFF;
	assign shortFlash = pairPhase_r == 2'h0 && sub_r < sli_pkg::SUB_SHORT_ON;

	always_comb
	begin
		genCol = sli_pkg::COL_OFF;
		if (cond_r[sli_pkg::COND_TAMPER])
			genCol = sli_pkg::COL_AMBER;
		else if (cond_r[sli_pkg::COND_FWUPD])
			genCol = sli_pkg::COL_RED;
		else if (pulseSub_r != 32'h0)
			genCol = pulseCol_r;
		else if (lowCnt_r != 5'h0)
			genCol = rapid ? sli_pkg::COL_RED : sli_pkg::COL_OFF;
		else if (ctrl_r[sli_pkg::CTRL_WIRELESS] && pending
			&& !cond_r[sli_pkg::COND_CONNECTED]
			&& pendSec_r != 6'(sli_pkg::PEND_TIMEOUT_S))
			genCol = rapid ? sli_pkg::COL_GREEN : sli_pkg::COL_OFF;
		else if (usb && ctrl_r[sli_pkg::CTRL_AUTHREQ] && cond_r[sli_pkg::COND_AUTHFAIL])
			genCol = sli_pkg::COL_RED;
		else if (usb && ctrl_r[sli_pkg::CTRL_AUTHREQ] && cond_r[sli_pkg::COND_AUTHOK])
			genCol = slowBlink ? sli_pkg::COL_GREEN : sli_pkg::COL_OFF;
		else if (usb && ctrl_r[sli_pkg::CTRL_AUTHREQ])
			genCol = sli_pkg::COL_GREEN;
		else if (usb && cond_r[sli_pkg::COND_CHARGING])
			genCol = mostly ? sli_pkg::COL_GREEN : sli_pkg::COL_OFF;
		else if (usb)
			genCol = sli_pkg::COL_GREEN;
	end

	always_comb
	begin
		blue = 1'b0;
		if (btn_r == sli_pkg::BTN_FLASH)
			blue = flashSub_r[1];
		else if (pressed_r)
			blue = 1'b1;
		else if (pairing && (usb || pairSec_r != 7'(sli_pkg::PAIR_LAMP_S)))
			blue = shortFlash;
		else if (ctrl_r[sli_pkg::CTRL_CONNLAMP] && cond_r[sli_pkg::COND_CONNECTED])
			blue = 1'b1;
	end

	assign status = {24'h0, pairRequest, btn_r == sli_pkg::BTN_FLASH, pressed_r,
		blueOn, redOn, amberOn, greenOn, pulseSub_r != 32'h0};

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			greenOn <= 1'b0;
			amberOn <= 1'b0;
			redOn <= 1'b0;
			blueOn <= 1'b0;
		end
		else
		begin
			greenOn <= genCol == sli_pkg::COL_GREEN;
			amberOn <= genCol == sli_pkg::COL_AMBER;
			redOn <= genCol == sli_pkg::COL_RED;
			blueOn <= blue;
		end
	end

endmodule // sli_status_lamps

// ==== test/sli_lamps_monitor.sv ====
// Port checker for the status lamp indicator
`timescale 1ns/1ps
module sli_lamps_monitor #(
	parameter int unsigned SEC_CYCLES = 64
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic buttonN,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic greenOn,
	input wire logic amberOn,
	input wire logic redOn,
	input wire logic blueOn,
	input wire logic pairRequest
);
	int unsigned holdCnt;
	// Kept after release, so the pairing pulse can be judged later
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			holdCnt <= 0;
		else if ($fell(buttonN))
			holdCnt <= 1;
		else if (!buttonN)
			holdCnt <= holdCnt + 1;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	lamp_onehot_a: assert property ($onehot0({greenOn, amberOn, redOn}))
		else $error("general lamp shows two colours");
	press_blue_a: assert property ($fell(buttonN) |-> ##[2:8] blueOn)
		else $error("blue not lit on press");
	pair_pulse_a: assert property (pairRequest |=> !pairRequest)
		else $error("pairing request longer than one cycle");
	pair_release_a: assert property (pairRequest |-> buttonN)
		else $error("pairing request while pressed");
	pair_hold_a: assert property (pairRequest |-> holdCnt >= 2 * SEC_CYCLES)
		else $error("pairing request after short press");
	bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read response dropped or changed");
	ar_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	aw_answer_a: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:3] s_axi_bvalid)
		else $error("write answer late");
	bad_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h0c
		|=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	cover property (pairRequest);
	cover property ($rose(amberOn));
	cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule // sli_lamps_monitor

bind sli_status_lamps sli_lamps_monitor #(.SEC_CYCLES(SEC_CYCLES)) mon (.ref_clk, .rstn,
	.buttonN, .s_axi_awvalid, .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
	.s_axi_rready, .greenOn, .amberOn, .redOn, .blueOn, .pairRequest);

// ==== test/sli_operator.sv ====
// Operator model: presses the button and watches all four lamps
`timescale 1ns/1ps
module sli_operator (
	input wire logic ref_clk,
	input wire logic press,
	input wire logic clr,
	input wire logic greenOn,
	input wire logic amberOn,
	input wire logic redOn,
	input wire logic blueOn,
	output logic buttonN,
	output int onG,
	output int onA,
	output int onR,
	output int onB,
	output int risesB
);
	logic lastB = 1'b0;
	initial buttonN = 1'b1;
	// Released button floats to its pull-up
	always @(posedge ref_clk)
	begin
		buttonN <= !press;
		lastB <= blueOn;
		onG <= clr ? 0 : onG + int'(greenOn);
		onA <= clr ? 0 : onA + int'(amberOn);
		onR <= clr ? 0 : onR + int'(redOn);
		onB <= clr ? 0 : onB + int'(blueOn);
		risesB <= clr ? 0 : risesB + int'(blueOn && !lastB);
	end
endmodule // sli_operator

// ==== test/sli_status_lamps_bench.sv ====
// Self-checking bench for the status lamp indicator
`timescale 1ns/1ps
module sli_status_lamps_bench;
	logic ref_clk = 1'b0, rstn = 1'b0, press = 1'b0, clr = 1'b0;
	logic [7:0] awAddr = 8'h00, arAddr = 8'h00;
	logic [31:0] wData = 32'h0, rData;
	logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
	logic awReady, wReady, bValid, arReady, rValid, buttonN;
	logic greenOn, amberOn, redOn, blueOn, pairRequest;
	logic [1:0] bResp, rResp;
	logic [2:0] e;
	int onG, onA, onR, onB, risesB, fails, comparisons, cyc, prCount, c, d;
	int seed = 32'hce16e91f;
	int sc[7] = '{0, 1, 3, 3, 0, 0, 1};
	int sd[7] = '{0, 0, 0, 4, 8, 16, 24};
	always #12.5 ref_clk = !ref_clk;
	sli_status_lamps #(.SEC_CYCLES(64)) dut (.ref_clk(ref_clk), .rstn(rstn),
		.buttonN(buttonN), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
		.s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
		.s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
		.s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
		.s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
		.greenOn(greenOn), .amberOn(amberOn), .redOn(redOn), .blueOn(blueOn),
		.pairRequest(pairRequest));
	sli_operator op (.ref_clk(ref_clk), .press(press), .clr(clr), .greenOn(greenOn),
		.amberOn(amberOn), .redOn(redOn), .blueOn(blueOn), .buttonN(buttonN),
		.onG(onG), .onA(onA), .onR(onR), .onB(onB), .risesB(risesB));
	// ----------
	// Model and shared tasks
	// ----------
	// Steady general colour as {red, amber, green}
	function automatic logic [2:0] bg(input int c, input int d);
		logic a, r;
		a = d[3];
		r = !a && (d[4] || (c == 3 && d[2]));
		return {r, a, !a && !r && c[0]};
	endfunction
	task automatic close_out();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		comparisons++;
		if (x !== g)
		begin
			fails++;
			$display("[FAIL] %s expected %0d seen %0d", n, x, g);
		end
	endtask
	task automatic look(input int g, input int a, input int r, input int b);
		chk("green", g, onG);
		chk("amber", a, onA);
		chk("red", r, onR);
		chk("blue", b, onB);
	endtask
	task automatic run(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic clear();
		clr <= 1'b1;
		@(posedge ref_clk);
		clr <= 1'b0;
	endtask
	task automatic meas(input int n);
		run(8);
		clear();
		run(n + 1);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] x);
		awAddr <= a;
		wData <= v;
		awValid <= 1'b1;
		wValid <= 1'b1;
		@(posedge ref_clk);
		while (awValid || wValid)
		begin
			if (awReady)
				awValid <= 1'b0;
			if (wReady)
				wValid <= 1'b0;
			@(posedge ref_clk);
		end
		while (!bValid)
			@(posedge ref_clk);
		bReady <= 1'b1;
		@(posedge ref_clk);
		chk("bresp", x, bResp);
		bReady <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [1:0] x);
		arAddr <= a;
		arValid <= 1'b1;
		@(posedge ref_clk);
		while (!arReady)
			@(posedge ref_clk);
		arValid <= 1'b0;
		while (!rValid)
			@(posedge ref_clk);
		rReady <= 1'b1;
		@(posedge ref_clk);
		chk("rdata", v, rData);
		chk("rresp", x, rResp);
		rReady <= 1'b0;
	endtask
	always @(posedge ref_clk)
	begin
		cyc++;
		if (pairRequest === 1'b1)
			prCount++;
		if (cyc == 20000)
		begin
			fails++;
			close_out();
		end
	end
	initial
	begin
		run(3);
		rstn <= 1'b1;
		@(posedge ref_clk);
		rd(8'h00, 0, 0);
		rd(8'h0c, 0, 0);
		rd(8'h10, 0, 2);
		wr(8'h0c, 1, 2);
		wr(8'h00, 7, 0);
		rd(8'h00, 7, 0);
		$display("test bus done");
		for (int i = 0; i < 12; i++)
		begin
			c = (i < 7) ? sc[i] : $random(seed) & 3;
			d = (i < 7) ? sd[i] : 8 * ($random(seed) & 3);
			wr(8'h00, c, 0);
			wr(8'h04, d, 0);
			e = bg(c, d);
			meas(64);
			look(64 * e[0], 64 * e[1], 64 * e[2], 0);
		end
		$display("test steady done");
		wr(8'h00, 1, 0);
		wr(8'h04, 1, 0);
		meas(64);
		look(56, 0, 0, 0);
		wr(8'h00, 3, 0);
		wr(8'h04, 2, 0);
		meas(128);
		look(64, 0, 0, 0);
		wr(8'h00, 8, 0);
		wr(8'h04, 64, 0);
		meas(64);
		look(32, 0, 0, 0);
		// Host connects for the transaction: flashing stops
		wr(8'h04, 192, 0);
		meas(64);
		look(0, 0, 0, 0);
		wr(8'h04, 64, 0);
		run(1300);
		meas(64);
		look(0, 0, 0, 0);
		wr(8'h00, 0, 0);
		wr(8'h04, 32, 0);
		wr(8'h08, 8, 0);
		clear();
		run(33);
		look(0, 0, 16, 0);
		run(40);
		meas(64);
		look(0, 0, 0, 0);
		$display("test patterns done");
		wr(8'h04, 0, 0);
		wr(8'h00, 8, 0);
		run(200);
		for (int k = 0; k < 3; k++)
		begin
			clear();
			wr(8'h08, 1 << k, 0);
			run(100);
			look(k == 0 ? 64 : 0, k == 2 ? 64 : 0, k == 1 ? 64 : 0, 0);
		end
		wr(8'h00, 9, 0);
		run(8);
		clear();
		wr(8'h08, 4, 0);
		run(100);
		chk("amber", 64, onA);
		meas(64);
		look(64, 0, 0, 0);
		$display("test results done");
		wr(8'h00, 4, 0);
		wr(8'h04, 128, 0);
		meas(64);
		look(0, 0, 0, 64);
		wr(8'h00, 0, 0);
		meas(64);
		look(0, 0, 0, 0);
		wr(8'h04, 256, 0);
		meas(256);
		chk("flashes", 2, risesB);
		run(3700);
		meas(128);
		look(0, 0, 0, 0);
		wr(8'h04, 0, 0);
		press <= 1'b1;
		meas(20);
		look(0, 0, 0, 20);
		press <= 1'b0;
		run(40);
		chk("pairing", 0, prCount);
		press <= 1'b1;
		run(240);
		press <= 1'b0;
		run(40);
		chk("pairing", 1, prCount);
		$display("test button done");
		close_out();
	end
endmodule // sli_status_lamps_bench
